// File: src/cbt_tx_ctrl.sv
// transmit buffer reservation, request and abort control with axi4-lite
`default_nettype none
module cbt_tx_ctrl
  import cbt_pkg::*;
#(
  parameter logic [3:0] GAP_BITS = GAP_BITS_DEF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cbt_core_in_t core_i,
  output cbt_core_out_t core_o
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic cbt_dec_t decode(logic [AW-1:0] a);
    cbt_dec_t d;
    d.kind = K_NONE;
    d.bufi = a[7:6] - 2'h1;
    d.idx = a[5:2];
    if (a == CSR_OFS)
      d.kind = K_CSR;
    else if (a[7:4] == BUFFER_CTRL_STATUS_OFS[7:4] && a[1:0] == 2'h0
             && a[3:2] < 2'(NBUF))
    begin
      d.kind = K_BUFFER_CTRL_STATUS;
      d.bufi = a[3:2];
    end
    else if (a >= MEM_OFS && a[1:0] == 2'h0 && a[5:2] < 4'(NBYTE))
      d.kind = K_MEM;
    return d;
  endfunction

  function automatic logic [1:0] pick(logic [NBUF-1:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = NBUF - 1; i >= 0; i--)
      if (m[i])
        r = 2'(i);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [AW-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_fire;
  cbt_dec_t wdec, rdec;
  logic [7:0] host_rdata, core_rdata;

  logic run_q, run_d, sync_q, sync_d, ack_q, ack_d, no_retransmit_bit_q, no_retransmit_bit_d;
  logic stby_q, stby_d, start_q, start_d;
  logic [NBUF-1:0] lock_q, lock_d, rdy_q, rdy_d, busy_q, busy_d;
  cbt_state_t st_q, st_d;
  logic [1:0] buf_q, buf_d, prep_q, prep_d;
  logic [3:0] gap_q, gap_d;
  logic [7:0] crd_q;
  logic ram_core_we, lock_clr, req_set;

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_arready = !r_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  assign wdec = decode(awa_q);
  assign rdec = decode(s_axi_araddr);
  assign wr_fire = aw_q && w_q && !b_q;

  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    b_d = b_q && !s_axi_bready;
    bresp_d = bresp_q;
    r_d = r_q && !s_axi_rready;
    rd_d = rd_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = (wdec.kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_d = 1'b1;
      rd_d = 32'h0;
      rresp_d = RESP_OKAY;
      case (rdec.kind)
        K_CSR:
        begin
          rd_d[CSR_RUN] = !stby_q;
          rd_d[CSR_SYNC] = ack_q;
          rd_d[CSR_NO_RETRANSMIT_BIT] = no_retransmit_bit_q;
        end
        K_BUFFER_CTRL_STATUS:
        begin
          rd_d[BC_LOCK] = lock_q[rdec.bufi];
          rd_d[BC_RDY] = rdy_q[rdec.bufi];
          rd_d[BC_BUSY] = busy_q[rdec.bufi];
        end
        K_MEM: rd_d[7:0] = host_rdata;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reservation, request and transmit sequencing
  // ----------------------------------------------------------------
  assign lock_clr = wr_fire && ws_q[0] && wdec.kind == K_BUFFER_CTRL_STATUS
                    && !wd_q[BC_LOCK];
  assign req_set = wr_fire && ws_q[0] && wdec.kind == K_MEM
                   && wdec.idx == DATA7_IDX && lock_q[wdec.bufi];

  always_comb
  begin
    run_d = run_q;
    sync_d = sync_q;
    no_retransmit_bit_d = no_retransmit_bit_q;
    lock_d = lock_q;
    rdy_d = rdy_q;
    busy_d = busy_q;
    st_d = st_q;
    buf_d = buf_q;
    prep_d = prep_q;
    gap_d = gap_q;
    start_d = 1'b0;
    if (wr_fire && ws_q[0] && wdec.kind == K_CSR)
    begin
      run_d = wd_q[CSR_RUN];
      sync_d = wd_q[CSR_SYNC];
      no_retransmit_bit_d = wd_q[CSR_NO_RETRANSMIT_BIT];
    end
    if (wr_fire && ws_q[0] && wdec.kind == K_BUFFER_CTRL_STATUS && wd_q[BC_LOCK])
      lock_d[wdec.bufi] = 1'b1;
    // a clear while busy is dropped; software repeats it later
    if (lock_clr && !busy_q[wdec.bufi])
    begin
      lock_d[wdec.bufi] = 1'b0;
      rdy_d[wdec.bufi] = 1'b0;
    end
    case (st_q)
      ST_IDLE:
      begin
        if (core_i.bit_tick && gap_q != 4'h0)
          gap_d = gap_q - 4'h1;
        // sync or standby hold the idle state
        if (gap_q == 4'h0 && run_q && !sync_q && |(rdy_d & lock_d))
        begin
          st_d = ST_PREP;
          buf_d = pick(rdy_d & lock_d);
          prep_d = 2'h0;
        end
      end
      ST_PREP:
      begin
        // a cancelled request ends here; no other content is sent
        if (!rdy_d[buf_q] || sync_q || !run_q)
          st_d = ST_IDLE;
        else if (core_i.bit_tick)
        begin
          prep_d = prep_q + 2'h1;
          if (prep_q == PREP_BITS - 2'h1)
          begin
            st_d = ST_ACTIVE;
            start_d = 1'b1;
            busy_d[buf_q] = 1'b1;
          end
        end
      end
      ST_ACTIVE:
      begin
        if (core_i.tx_ok || core_i.tx_err || core_i.tx_arb_lost)
        begin
          st_d = ST_IDLE;
          gap_d = GAP_BITS;
          busy_d[buf_q] = 1'b0;
          if (core_i.tx_ok)
            rdy_d[buf_q] = 1'b0;
          else if (core_i.tx_err && no_retransmit_bit_q)
            rdy_d[buf_q] = 1'b0;
          // lost arbitration leaves the request pending
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (req_set)
      rdy_d[wdec.bufi] = 1'b1;
  end

  // sync reads one only when no internal request is being prepared
  assign ack_d = sync_q && st_q != ST_PREP;
  assign stby_d = !run_q && st_q == ST_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      rd_q <= 32'h0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      run_q <= 1'b0;
      sync_q <= 1'b0;
      ack_q <= 1'b0;
      no_retransmit_bit_q <= 1'b0;
      stby_q <= 1'b1;
      start_q <= 1'b0;
      lock_q <= '0;
      rdy_q <= '0;
      busy_q <= '0;
      st_q <= ST_IDLE;
      buf_q <= 2'h0;
      prep_q <= 2'h0;
      gap_q <= 4'h0;
      crd_q <= 8'h00;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      run_q <= run_d;
      sync_q <= sync_d;
      ack_q <= ack_d;
      no_retransmit_bit_q <= no_retransmit_bit_d;
      stby_q <= stby_d;
      start_q <= start_d;
      lock_q <= lock_d;
      rdy_q <= rdy_d;
      busy_q <= busy_d;
      st_q <= st_d;
      buf_q <= buf_d;
      prep_q <= prep_d;
      gap_q <= gap_d;
      crd_q <= core_rdata;
    end
  end

  // ----------------------------------------------------------------
  // buffer memory and core side
  // ----------------------------------------------------------------
  assign ram_core_we = core_i.rx_we && core_i.rx_buf < 2'(NBUF)
                       && !lock_q[core_i.rx_buf];

  cbt_msg_ram u_ram (
    .aclk(aclk),
    .aresetn(aresetn),
    .host_we(wr_fire && ws_q[0] && wdec.kind == K_MEM),
    .host_buf(wdec.bufi),
    .host_idx(wdec.idx),
    .host_data(wd_q[7:0]),
    .host_rbuf(rdec.bufi),
    .host_ridx(rdec.idx),
    .host_rdata(host_rdata),
    .core_we(ram_core_we),
    .core_buf(core_i.rx_buf),
    .core_idx(core_i.rx_idx),
    .core_data(core_i.rx_byte),
    .core_rbuf(buf_q),
    .core_ridx(core_i.rd_idx),
    .core_rdata(core_rdata)
  );

  assign core_o.tx_start = start_q;
  assign core_o.tx_buf = buf_q;
  assign core_o.tx_active = st_q == ST_ACTIVE;
  assign core_o.rx_accept = ~lock_q;
  assign core_o.rd_data = crd_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rx_gate_a: assert property (
    core_i.rx_we && lock_q[core_i.rx_buf] |-> !ram_core_we)
    else $error("received byte stored into reserved buffer");
  req_set_a: assert property (
    req_set |=> rdy_q[$past(wdec.bufi)])
    else $error("byte 7 write did not raise pending");
  cancel_now_a: assert property (
    lock_clr && !busy_q[wdec.bufi] && !req_set
    |=> !rdy_q[$past(wdec.bufi)] && !lock_q[$past(wdec.bufi)])
    else $error("idle pending frame not cancelled");
  busy_hold_a: assert property (
    lock_clr && busy_q[wdec.bufi] |=> lock_q[$past(wdec.bufi)])
    else $error("lock released while busy");
  prep_stop_a: assert property (
    st_q == ST_PREP && !rdy_q[buf_q] |=> !start_q ##1 st_q != ST_ACTIVE)
    else $error("cancelled preparation still started a frame");
  sync_ack_a: assert property (
    $rose(sync_q) && run_q |-> ##[1:2] ack_q)
    else $error("abort sync not acknowledged");
  sync_block_a: assert property (
    sync_q && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("transmission started while sync set");
  ok_clear_a: assert property (
    st_q == ST_ACTIVE && core_i.tx_ok && !req_set
    |=> !rdy_q[$past(buf_q)] && !busy_q[$past(buf_q)])
    else $error("success left buffer pending");
  no_retransmit_bit_drop_a: assert property (
    st_q == ST_ACTIVE && core_i.tx_err && !core_i.tx_ok && no_retransmit_bit_q
    && !req_set |=> !rdy_q[$past(buf_q)])
    else $error("errored frame kept despite no-retransmit");
  arb_keep_a: assert property (
    st_q == ST_ACTIVE && core_i.tx_arb_lost && !core_i.tx_ok
    && !core_i.tx_err |=> rdy_q[$past(buf_q)] && st_q == ST_IDLE)
    else $error("lost arbitration dropped the frame");
  standby_a: assert property (
    st_q == ST_ACTIVE && !run_q ##1 st_q == ST_IDLE && !run_q
    |=> stby_q)
    else $error("standby not entered after attempt");
  gap_hold_a: assert property (
    st_q == ST_IDLE && gap_q != 4'h0 |=> st_q != ST_PREP)
    else $error("preparation inside the post-busy gap");

  tx_ok_c: cover property (start_q ##[1:100] core_i.tx_ok);
  sync_abort_c: cover property (ack_q && lock_clr);
  arb_c: cover property (st_q == ST_ACTIVE && core_i.tx_arb_lost);
endmodule
`default_nettype wire

// File: inc/cbt_pkg.sv
// package of constants and types for the can transmit buffer abort control
`default_nettype none
package cbt_pkg;
  // buffers, bytes per buffer and the byte that raises a request
  localparam int NBUF = 3;
  localparam int NBYTE = 10;
  localparam logic [3:0] DATA7_IDX = 4'h9;
  // preparation window before start of frame, in bit times
  localparam logic [1:0] PREP_BITS = 2'h2;
  // quiet bit times after a busy fall before a new preparation
  localparam logic [3:0] GAP_BITS_DEF = 4'h3;
  // register byte addresses
  localparam int AW = 8;
  localparam logic [7:0] CSR_OFS = 8'h00;
  localparam logic [7:0] BUFFER_CTRL_STATUS_OFS = 8'h10;
  localparam logic [7:0] MEM_OFS = 8'h40;
  // controller control/status fields
  localparam int CSR_RUN = 0;
  localparam int CSR_SYNC = 1;
  localparam int CSR_NO_RETRANSMIT_BIT = 2;
  // buffer control/status fields
  localparam int BC_LOCK = 0;
  localparam int BC_RDY = 1;
  localparam int BC_BUSY = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    K_CSR = 2'h0,
    K_BUFFER_CTRL_STATUS = 2'h1,
    K_MEM = 2'h2,
    K_NONE = 2'h3
  } cbt_kind_t;

  // gray along idle, prep, active
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PREP = 2'h1,
    ST_ACTIVE = 2'h3
  } cbt_state_t;

  typedef struct packed {
    cbt_kind_t kind;
    logic [1:0] bufi;
    logic [3:0] idx;
  } cbt_dec_t;

  // from the protocol core, same clock
  typedef struct packed {
    logic bit_tick;
    logic tx_ok;
    logic tx_err;
    logic tx_arb_lost;
    logic rx_we;
    logic [1:0] rx_buf;
    logic [3:0] rx_idx;
    logic [7:0] rx_byte;
    logic [3:0] rd_idx;
  } cbt_core_in_t;

  // to the protocol core
  typedef struct packed {
    logic tx_start;
    logic [1:0] tx_buf;
    logic tx_active;
    logic [NBUF-1:0] rx_accept;
    logic [7:0] rd_data;
  } cbt_core_out_t;
endpackage
`default_nettype wire

// File: src/cbt_msg_ram.sv
// dual-ported message buffer memory with write conflict arbitration
`default_nettype none
module cbt_msg_ram
  import cbt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_we,
  input wire logic [1:0] host_buf,
  input wire logic [3:0] host_idx,
  input wire logic [7:0] host_data,
  input wire logic [1:0] host_rbuf,
  input wire logic [3:0] host_ridx,
  output logic [7:0] host_rdata,
  input wire logic core_we,
  input wire logic [1:0] core_buf,
  input wire logic [3:0] core_idx,
  input wire logic [7:0] core_data,
  input wire logic [1:0] core_rbuf,
  input wire logic [3:0] core_ridx,
  output logic [7:0] core_rdata
);
  logic [7:0] mem_q [NBUF*NBYTE];
  logic park_q, park_d;
  logic [1:0] pbuf_q, pbuf_d;
  logic [3:0] pidx_q, pidx_d;
  logic [7:0] pdat_q, pdat_d;
  logic hw_en;
  logic [1:0] hw_buf;
  logic [3:0] hw_idx;
  logic [7:0] hw_dat;

  function automatic int addr(logic [1:0] b, logic [3:0] i);
    addr = int'(b) * NBYTE + int'(i);
  endfunction

  // ----------------------------------------------------------------
  // port arbitration
  // ----------------------------------------------------------------
  always_comb
  begin
    hw_en = park_q | host_we;
    hw_buf = park_q ? pbuf_q : host_buf;
    hw_idx = park_q ? pidx_q : host_idx;
    hw_dat = park_q ? pdat_q : host_data;
    // core byte wins, a host write is parked whole, never split
    park_d = hw_en & core_we;
    pbuf_d = hw_buf;
    pidx_d = hw_idx;
    pdat_d = hw_dat;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      park_q <= 1'b0;
      pbuf_q <= 2'h0;
      pidx_q <= 4'h0;
      pdat_q <= 8'h00;
    end
    else
    begin
      park_q <= park_d;
      pbuf_q <= pbuf_d;
      pidx_q <= pidx_d;
      pdat_q <= pdat_d;
    end
  end

  // received bytes land one at a time from the core port
  always_ff @(posedge aclk)
  begin
    if (core_we)
      mem_q[addr(core_buf, core_idx)] <= core_data;
    else if (hw_en)
      mem_q[addr(hw_buf, hw_idx)] <= hw_dat;
  end

  assign host_rdata = mem_q[addr(host_rbuf, host_ridx)];
  assign core_rdata = mem_q[addr(core_rbuf, core_ridx)];

  park_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_we && core_we |=> park_q && pdat_q == $past(host_data))
    else $error("host write lost in port conflict");
endmodule
`default_nettype wire

// File: testbench/cbt_core_model.sv
// protocol core and bus side model driving the controller core port
`default_nettype none
module cbt_core_model
  import cbt_pkg::*;
#(
  parameter int TICK_DIV = 8,
  parameter int HOLD = 40
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cbt_core_out_t core_o,
  output cbt_core_in_t core_i,
  input wire logic [1:0] outcome,
  input wire logic rx_go,
  input wire logic [1:0] rx_buf,
  input wire logic [3:0] rx_idx,
  input wire logic [7:0] rx_byte,
  input wire logic [3:0] rd_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_q;
  int act_q;
  logic end_now;
  assign end_now = core_o.tx_active && act_q == HOLD;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 0;
      act_q <= 0;
      core_i <= '0;
    end
    else
    begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      core_i.bit_tick <= div_q == TICK_DIV - 1;
      act_q <= core_o.tx_active ? act_q + 1 : 0;
      // one attempt end pulse, kind chosen by the bench
      core_i.tx_ok <= end_now && outcome == 2'h0;
      core_i.tx_err <= end_now && outcome == 2'h1;
      core_i.tx_arb_lost <= end_now && outcome == 2'h2;
      // received bytes, one at a time; idle data toggles
      core_i.rx_we <= rx_go;
      core_i.rx_buf <= rx_buf;
      core_i.rx_idx <= rx_idx;
      core_i.rx_byte <= rx_go ? rx_byte : ~core_i.rx_byte;
      core_i.rd_idx <= rd_idx;
    end
  end
endmodule
`default_nettype wire

// File: testbench/cbt_tx_ctrl_tb.sv
// self-checking bench for the transmit buffer abort control
`default_nettype none
module cbt_tx_ctrl_tb
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
  logic [31:0] wdata = '0;
  logic awr, wrdy, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  cbt_core_in_t core_i;
  cbt_core_out_t core_o;
  logic [1:0] outcome = 2'h0, rx_buf = 2'h0;
  logic rx_go = 1'h0;
  logic [3:0] rx_idx = 4'h0, rd_idx = 4'h0;
  logic [7:0] rx_byte = 8'h0;
  int failures = 0, n_checks = 0, n_start = 0, s;

  always #5 aclk = ~aclk;
  always @(negedge aclk)
    if (core_o.tx_start === 1'h1)
      n_start++;

  cbt_tx_ctrl #(.GAP_BITS(GAP_BITS_DEF)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .core_i(core_i), .core_o(core_o));

  cbt_core_model model (.aclk(aclk), .aresetn(aresetn), .core_o(core_o),
    .core_i(core_i), .outcome(outcome), .rx_go(rx_go), .rx_buf(rx_buf),
    .rx_idx(rx_idx), .rx_byte(rx_byte), .rd_idx(rd_idx));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic ah, wh, bh;
    logic [1:0] r;
    bh = 1'h0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    for (int t = 0; t < 40 && !bh; t++)
    begin
      @(negedge aclk);
      ah = awv && awr;
      wh = wv && wrdy;
      bh = bv;
      r = bresp;
      @(posedge aclk);
      if (ah)
        awv <= 1'h0;
      if (wh)
        wv <= 1'h0;
    end
    chk({bh, r}, {1'h1, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic ah, rh;
    logic [1:0] r;
    rh = 1'h0;
    araddr <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    for (int t = 0; t < 40 && !rh; t++)
    begin
      @(negedge aclk);
      ah = arv && arr;
      rh = rv;
      r = rresp;
      d = rdata;
      @(posedge aclk);
      if (ah)
        arv <= 1'h0;
    end
    chk({rh, r}, {1'h1, er}, "read response");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = RESP_OKAY);
    rd(a, v, er);
    chk(v, e, "read data");
  endtask

  task automatic rx(input logic [1:0] b, input logic [3:0] i,
    input logic [7:0] d);
    rx_buf <= b;
    rx_idx <= i;
    rx_byte <= d;
    rx_go <= 1'h1;
    @(posedge aclk);
    rx_go <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic wait_start();
    s = n_start;
    for (int t = 0; t < 200 && n_start == s; t++)
      @(posedge aclk);
    chk(n_start, s + 1, "frame start");
  endtask

  task automatic wait_end();
    for (int t = 0; t < 200 && core_o.tx_active !== 1'h0; t++)
      @(posedge aclk);
    chk(core_o.tx_active, 1'h0, "attempt end");
  endtask

  task automatic quiet(input int n);
    s = n_start;
    repeat (n) @(posedge aclk);
    chk(n_start, s, "no frame start");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #300us;
    failures++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    chk(core_o.rx_accept, 3'h7, "receive after reset");
    rdc(CSR_OFS, 32'h0);
    for (int b = 0; b < NBUF; b++)
      rdc(BUFFER_CTRL_STATUS_OFS + 8'(4 * b), 32'h0);
    rdc(8'h0C, 32'h0, RESP_SLVERR);
    wr(8'h68, 32'h0, RESP_SLVERR);
    $display("reset and map test done");
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    chk(core_o.rx_accept, 3'h5, "reserved refuses");
    wr(8'h88, 32'h55);
    rx(2'h1, 4'h2, 8'hAA);
    rdc(8'h88, 32'h55);
    rx(2'h0, 4'h3, 8'h3C);
    rdc(8'h4C, 32'h3C);
    fork
      wr(8'h50, 32'hC4);
      rx(2'h0, 4'h5, 8'h5B);
    join
    rdc(8'h50, 32'hC4);
    rdc(8'h54, 32'h5B);
    wr(8'hE4, 32'h1);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h8, 32'h0);
    wr(8'hA4, 32'hA7);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h3);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    $display("receive and cancel test done");
    wr(CSR_OFS, 32'h1);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    wr(8'hA4, 32'hA7);
    rd_idx <= DATA7_IDX;
    wait_start();
    chk(core_o.tx_buf, 2'h1, "sending buffer");
    repeat (3) @(posedge aclk);
    chk(core_o.rd_data, 8'hA7, "core reads byte");
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h7);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h7);
    wait_end();
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    $display("success test done");
    outcome <= 2'h2;
    wr(8'hA4, 32'hA7);
    wait_start();
    wait_end();
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h3);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    quiet(80);
    $display("arbitration test done");
    outcome <= 2'h1;
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    wr(8'hA4, 32'hA7);
    wait_start();
    wait_end();
    outcome <= 2'h0;
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h3);
    wait_start();
    wait_end();
    outcome <= 2'h1;
    wr(CSR_OFS, 32'h5);
    wr(8'hA4, 32'hA7);
    wait_start();
    wait_end();
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    quiet(60);
    $display("error test done");
    wr(CSR_OFS, 32'h1);
    outcome <= 2'h0;
    wr(8'hA4, 32'hA7);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    quiet(80);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    $display("preparation test done");
    wr(CSR_OFS, 32'h3);
    v = '0;
    for (int t = 0; t < 6 && v[CSR_SYNC] !== 1'h1; t++)
      rd(CSR_OFS, v);
    chk(v[CSR_SYNC], 1'h1, "sync acknowledge");
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    wr(8'hA4, 32'hA7);
    quiet(60);
    v = 32'h1;
    for (int t = 0; t < 4 && v[BC_LOCK] !== 1'h0; t++)
    begin
      wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
      rd(BUFFER_CTRL_STATUS_OFS + 8'h4, v);
    end
    chk(v, 32'h0, "synchronised abort");
    wr(CSR_OFS, 32'h1);
    $display("sync abort test done");
    outcome <= 2'h2;
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h1);
    wr(8'hA4, 32'hA7);
    wait_start();
    wr(CSR_OFS, 32'h0);
    rdc(CSR_OFS, 32'h1);
    wait_end();
    repeat (3) @(posedge aclk);
    rdc(CSR_OFS, 32'h0);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h3);
    quiet(60);
    wr(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    rdc(BUFFER_CTRL_STATUS_OFS + 8'h4, 32'h0);
    $display("standby test done");
    wrap_up();
  end
endmodule
`default_nettype wire
